// >>> hw/fcm_cycle.sv
/*
  one flash bus cycle, read or write, with timed strobes.
  registers address and data at start, so the caller need not hold them steady until done.
*/
module fcm_cycle
(
  input wire logic i_clk,
  input wire logic i_reset,
  input wire logic i_start,
  input wire logic i_write,
  input wire fcm_pkg::fcm_cmd_t i_cmd,
  input wire logic [fcm_pkg::FD_W-1:0] i_dq,
  output fcm_pkg::fcm_pins_t o_pins,
  output logic o_done,
  output logic [fcm_pkg::FD_W-1:0] o_rdata
);
  import fcm_pkg::*;

  // cycle phases
  typedef enum logic [3:0] {
    CY_IDLE = 4'h1,
    CY_SETUP = 4'h2,
    CY_STROBE = 4'h4,
    CY_HOLD = 4'h8
  } fcm_cy_t;

  fcm_cy_t state, next_state;
  fcm_pins_t pins, next_pins; // registered pin levels
  logic [CNT_W-1:0] cnt, next_cnt; // phase timer
  logic is_wr, next_is_wr; // current cycle writes
  logic done, next_done;
  logic [FD_W-1:0] rdata, next_rdata;

  // next values of the cycle engine
  always_comb
  begin
    next_state = state;
    next_pins = pins;
    next_cnt = cnt;
    next_is_wr = is_wr;
    next_done = 1'b0;
    next_rdata = rdata;
    unique case (state)
      CY_IDLE:
      begin
        // chip select first, strobe falls later so address is latched then
        if (i_start)
        begin
          next_state = CY_SETUP;
          next_is_wr = i_write;
          next_pins.ce_n = 1'b0;
          next_pins.addr = i_cmd.addr;
          next_pins.dq = i_cmd.data;
          next_pins.dq_oe = i_write;
          next_cnt = C_SETUP;
        end
      end
      CY_SETUP:
      begin
        next_cnt = cnt - CNT_ONE;
        if (cnt == CNT_ONE)
        begin
          next_state = CY_STROBE;
          next_pins.we_n = ~is_wr;
          next_pins.oe_n = is_wr;
          next_cnt = is_wr ? C_WPULSE : C_RACC;
        end
      end
      CY_STROBE:
      begin
        next_cnt = cnt - CNT_ONE;
        if (cnt == CNT_ONE)
        begin
          next_state = CY_HOLD;
          next_pins.we_n = 1'b1;
          next_pins.oe_n = 1'b1;
          next_cnt = C_HOLD;
          if (!is_wr) next_rdata = i_dq;
        end
      end
      CY_HOLD:
      begin
        // data stays driven through the hold, then chip select drops away
        next_cnt = cnt - CNT_ONE;
        if (cnt == CNT_ONE)
        begin
          next_state = CY_IDLE;
          next_pins.ce_n = 1'b1;
          next_pins.dq_oe = 1'b0;
          next_done = 1'b1;
        end
      end
    endcase
  end

  // register the cycle engine
  always_ff @(posedge i_clk)
  begin
    if (i_reset)
    begin
      state <= CY_IDLE;
      pins <= '{ce_n: 1'b1, we_n: 1'b1, oe_n: 1'b1, addr: '0, dq: '0, dq_oe: 1'b0};
      cnt <= CNT_ZERO;
      is_wr <= 1'b0;
      done <= 1'b0;
      rdata <= '0;
    end
    else
    begin
      state <= next_state;
      pins <= next_pins;
      cnt <= next_cnt;
      is_wr <= next_is_wr;
      done <= next_done;
      rdata <= next_rdata;
    end
  end

  assign o_pins = pins;
  assign o_done = done;
  assign o_rdata = rdata;

endmodule

// >>> hw/fcm_host.sv
/*
  host controller for a parallel nor flash: takes orders over ahb-lite,
  issues command sequences and reads on the flash pins, polls for completion.
  assumes a single ahb-lite master, flash pins synchronous to I_MCLK,
  and an external switch that raises the reset pin to the high voltage level
  while O_FL_HV_REQ is high.
*/
// The register offsets and the AHB-Lite slave port are this design's own decisions.
module fcm_host
(
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic I_HSEL,
  input wire logic [31:0] I_HADDR,
  input wire logic [1:0] I_HTRANS,
  input wire logic I_HWRITE,
  input wire logic [2:0] I_HSIZE,
  input wire logic [31:0] I_HWDATA,
  input wire logic I_HREADY,
  output logic [31:0] O_HRDATA,
  output logic O_HREADYOUT,
  output logic O_HRESP,
  output logic [fcm_pkg::FA_W-1:0] O_FL_ADDR,
  output logic O_FL_CE_N,
  output logic O_FL_WE_N,
  output logic O_FL_OE_N,
  input wire logic [fcm_pkg::FD_W-1:0] I_FL_DQ,
  output logic [fcm_pkg::FD_W-1:0] O_FL_DQ,
  output logic O_FL_DQ_OE,
  output logic O_FL_BYTE_N,
  output logic O_FL_RESET_N,
  output logic O_FL_HV_REQ,
  input wire logic I_FL_OP_DONE_N
);
  import fcm_pkg::*;

  // sequencer states
  typedef enum logic [8:0] {
    S_IDLE = 9'h001,
    S_WR = 9'h002,
    S_WRW = 9'h004,
    S_RD = 9'h008,
    S_RDW = 9'h010,
    S_SETTLE = 9'h020,
    S_POLL = 9'h040,
    S_POLLW = 9'h080,
    S_RST = 9'h100
  } fcm_st_t;

  // ---------------- ahb-lite slave ----------------
  logic dp_wr, next_dp_wr; // data phase of a write pending
  logic [7:0] dp_addr, next_dp_addr; // its register offset
  logic [31:0] hrdata, next_hrdata; // read data for the data phase
  logic hresp; // always okay

  // software visible registers
  logic [2:0] op, next_op; // operation to run
  logic byte_mode, next_byte_mode; // byte width select
  logic fl_byte_n; // byte width pin level, low for byte
  logic hv_req, next_hv_req; // temporary unprotect request
  logic [FA_W-1:0] taddr, next_taddr; // target address
  logic [FD_W-1:0] tdata, next_tdata; // target data
  logic [FD_W-1:0] rdat, next_rdat; // last read result
  logic done, next_done; // sticky completion
  logic err, next_err; // sticky time limit failure
  logic autosel, next_autosel; // device left in autoselect mode
  logic start; // start request this cycle

  // sequencer state
  fcm_st_t state, next_state;
  logic [2:0] sop, next_sop; // operation being sent
  logic [2:0] step, next_step; // command write index
  logic [CNT_W-1:0] cnt, next_cnt; // settle and reset timer
  logic rst_n, next_rst_n; // hardware reset pin level
  logic cy_go, next_cy_go; // start pulse to cycle engine
  logic cy_wr, next_cy_wr; // cycle engine writes
  fcm_cmd_t cy_cmd, next_cy_cmd; // address and data of the cycle
  logic cy_done;
  logic [FD_W-1:0] cy_rdata;
  fcm_pins_t pins;

  // status word assembled from live state
  function automatic logic [31:0] stat_word(input logic busy, input logic dn, input logic er,
                                            input logic asel, input logic rdy);
    logic [31:0] w;
    w = '0;
    w[ST_BUSY] = busy;
    w[ST_DONE] = dn;
    w[ST_ERR] = er;
    w[ST_AUTOSEL] = asel;
    w[ST_RDY] = rdy;
    return w;
  endfunction

  // bus decode and register next values
  always_comb
  begin
    logic addr_ph;
    logic [31:0] ctrl_w;
    addr_ph = I_HSEL && I_HREADY && I_HTRANS[1];
    next_dp_wr = addr_ph && I_HWRITE;
    next_dp_addr = addr_ph ? I_HADDR[7:0] : dp_addr;
    next_hrdata = hrdata;
    next_op = op;
    next_byte_mode = byte_mode;
    next_hv_req = hv_req;
    next_taddr = taddr;
    next_tdata = tdata;
    start = 1'b0;
    ctrl_w = '0;
    ctrl_w[CTRL_BYTE] = byte_mode;
    ctrl_w[CTRL_HV] = hv_req;
    ctrl_w[CTRL_OP_HI:CTRL_OP_LO] = op;
    // read data is prepared in the address phase, zero wait states
    if (addr_ph && !I_HWRITE)
    begin
      unique case (I_HADDR[7:0])
        REG_CTRL: next_hrdata = ctrl_w;
        REG_ADDR: next_hrdata = {{(32-FA_W){1'b0}}, taddr};
        REG_DATA: next_hrdata = {{(32-FD_W){1'b0}}, tdata};
        REG_STAT: next_hrdata = stat_word(state != S_IDLE, done, err, autosel,
                                          I_FL_OP_DONE_N);
        REG_RDAT: next_hrdata = {{(32-FD_W){1'b0}}, rdat};
        default: next_hrdata = '0;
      endcase
    end
    // writes land in the data phase
    if (dp_wr)
    begin
      unique case (dp_addr)
        REG_CTRL:
        begin
          if (state == S_IDLE)
          begin
            next_op = I_HWDATA[CTRL_OP_HI:CTRL_OP_LO];
            next_byte_mode = I_HWDATA[CTRL_BYTE];
            start = I_HWDATA[CTRL_START];
          end
          next_hv_req = I_HWDATA[CTRL_HV];
        end
        REG_ADDR: next_taddr = I_HWDATA[FA_W-1:0];
        REG_DATA: next_tdata = I_HWDATA[FD_W-1:0];
        default: next_tdata = tdata;
      endcase
    end
  end

  // sequencer next values
  always_comb
  begin
    logic clr_done;
    logic clr_err;
    logic fin;
    logic set_err;
    logic [2:0] nw;
    nw = fcm_nwrites(sop);
    fin = 1'b0;
    set_err = 1'b0;
    next_state = state;
    next_sop = sop;
    next_step = step;
    next_cnt = cnt;
    next_rst_n = 1'b1;
    next_cy_go = 1'b0;
    next_cy_wr = cy_wr;
    next_cy_cmd = cy_cmd;
    next_rdat = rdat;
    next_autosel = autosel;
    next_err = err;
    unique case (state)
      S_IDLE:
      begin
        next_sop = next_op;
        next_step = 3'h0;
        if (start)
        begin
          if (next_op == OP_READ)
            next_state = S_RD;
          else if (next_op == OP_HWRESET)
          begin
            next_state = S_RST;
            next_cnt = C_RST;
            next_rst_n = 1'b0;
          end
          else
            next_state = S_WR;
        end
      end
      S_WR:
      begin
        next_cy_cmd = fcm_cmd(sop, step, byte_mode, '{addr: taddr, data: tdata});
        next_cy_wr = 1'b1;
        next_cy_go = 1'b1;
        next_state = S_WRW;
      end
      S_WRW:
      begin
        if (cy_done)
        begin
          if (step == nw - 3'h1)
          begin
            if (sop == OP_PROG || sop == OP_ERASE)
            begin
              next_state = S_SETTLE;
              next_cnt = C_BUSY;
            end
            else
            begin
              next_autosel = (sop == OP_AUTOSEL);
              fin = 1'b1;
            end
          end
          else
          begin
            next_step = step + 3'h1;
            next_state = S_WR;
          end
        end
      end
      S_RD:
      begin
        next_cy_cmd = '{addr: taddr, data: tdata};
        next_cy_wr = 1'b0;
        next_cy_go = 1'b1;
        next_state = S_RDW;
      end
      S_RDW:
      begin
        if (cy_done)
        begin
          next_rdat = cy_rdata;
          fin = 1'b1;
        end
      end
      S_SETTLE:
      begin
        // ready/busy needs time to fall after the last write
        next_cnt = cnt - CNT_ONE;
        if (cnt == CNT_ONE) next_state = S_POLL;
      end
      S_POLL:
      begin
        if (I_FL_OP_DONE_N)
          fin = 1'b1;
        else
        begin
          next_cy_cmd = '{addr: taddr, data: tdata};
          next_cy_wr = 1'b0;
          next_cy_go = 1'b1;
          next_state = S_POLLW;
        end
      end
      S_POLLW:
      begin
        if (cy_done)
        begin
          next_rdat = cy_rdata;
          next_state = S_POLL;
          if (cy_rdata[TIME_LIMIT_BIT] && !I_FL_OP_DONE_N)
          begin
            set_err = 1'b1;
            next_sop = OP_RESET;
            next_step = 3'h0;
            next_state = S_WR;
          end
        end
      end
      S_RST:
      begin
        next_cnt = cnt - CNT_ONE;
        next_rst_n = 1'b0;
        if (cnt == CNT_ONE)
        begin
          next_rst_n = 1'b1;
          next_autosel = 1'b0;
          fin = 1'b1;
        end
      end
    endcase
    if (fin) next_state = S_IDLE;
    // sticky flags: a new event wins over a clear in the same cycle
    clr_done = dp_wr && dp_addr == REG_STAT && I_HWDATA[ST_DONE];
    clr_err = dp_wr && dp_addr == REG_STAT && I_HWDATA[ST_ERR];
    next_done = fin | (done & ~clr_done);
    next_err = set_err | (err & ~clr_err);
  end

  // register everything
  always_ff @(posedge I_MCLK)
  begin
    if (I_RESET)
    begin
      dp_wr <= 1'b0;
      dp_addr <= 8'h00;
      hrdata <= 32'h0000_0000;
      hresp <= 1'b0;
      op <= OP_READ;
      byte_mode <= 1'b0;
      fl_byte_n <= 1'b1;
      hv_req <= 1'b0;
      taddr <= '0;
      tdata <= '0;
      rdat <= '0;
      done <= 1'b0;
      err <= 1'b0;
      autosel <= 1'b0;
      state <= S_IDLE;
      sop <= OP_READ;
      step <= 3'h0;
      cnt <= CNT_ZERO;
      rst_n <= 1'b1;
      cy_go <= 1'b0;
      cy_wr <= 1'b0;
      cy_cmd <= '0;
    end
    else
    begin
      dp_wr <= next_dp_wr;
      dp_addr <= next_dp_addr;
      hrdata <= next_hrdata;
      hresp <= 1'b0;
      op <= next_op;
      byte_mode <= next_byte_mode;
      fl_byte_n <= ~next_byte_mode;
      hv_req <= next_hv_req;
      taddr <= next_taddr;
      tdata <= next_tdata;
      rdat <= next_rdat;
      done <= next_done;
      err <= next_err;
      autosel <= next_autosel;
      state <= next_state;
      sop <= next_sop;
      step <= next_step;
      cnt <= next_cnt;
      rst_n <= next_rst_n;
      cy_go <= next_cy_go;
      cy_wr <= next_cy_wr;
      cy_cmd <= next_cy_cmd;
    end
  end

  // timed bus cycles on the flash pins
  fcm_cycle u_cycle
  (
    .i_clk(I_MCLK),
    .i_reset(I_RESET),
    .i_start(cy_go),
    .i_write(cy_wr),
    .i_cmd(cy_cmd),
    .i_dq(I_FL_DQ),
    .o_pins(pins),
    .o_done(cy_done),
    .o_rdata(cy_rdata)
  );

  // outputs from flip-flops, except O_HREADYOUT tied high
  assign O_HRDATA = hrdata;
  assign O_HREADYOUT = 1'b1;
  assign O_HRESP = hresp;
  assign O_FL_ADDR = pins.addr;
  assign O_FL_CE_N = pins.ce_n;
  assign O_FL_WE_N = pins.we_n;
  assign O_FL_OE_N = pins.oe_n;
  assign O_FL_DQ = pins.dq;
  assign O_FL_DQ_OE = pins.dq_oe;
  assign O_FL_BYTE_N = fl_byte_n;
  assign O_FL_RESET_N = rst_n;
  assign O_FL_HV_REQ = hv_req;

endmodule

// >>> hw/fcm_pkg.sv
/*
  package of the flash command host: register map, field positions,
  command table, bus cycle timing and shared types.
  assumes a 250 MHz system clock and a parallel nor flash on the far side.
*/
package fcm_pkg;

  // clock period in ns
  localparam int CLK_NS = 4;

  // flash address and data widths, timer width
  localparam int FA_W = 18;
  localparam int FD_W = 16;
  localparam int CNT_W = 8;

  // register byte offsets
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_ADDR = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam logic [7:0] REG_STAT = 8'h0C;
  localparam logic [7:0] REG_RDAT = 8'h10;

  // control register fields
  localparam int CTRL_START = 0;
  localparam int CTRL_BYTE = 1;
  localparam int CTRL_HV = 2;
  localparam int CTRL_OP_LO = 4;
  localparam int CTRL_OP_HI = 6;

  // status register fields
  localparam int ST_BUSY = 0;
  localparam int ST_DONE = 1;
  localparam int ST_ERR = 2;
  localparam int ST_AUTOSEL = 3;
  localparam int ST_RDY = 4;

  // data bit that carries the time limit flag
  localparam int TIME_LIMIT_BIT = 5;

  // operation codes
  localparam logic [2:0] OP_READ = 3'h0;
  localparam logic [2:0] OP_RESET = 3'h1;
  localparam logic [2:0] OP_AUTOSEL = 3'h2;
  localparam logic [2:0] OP_PROG = 3'h3;
  localparam logic [2:0] OP_ERASE = 3'h4;
  localparam logic [2:0] OP_HWRESET = 3'h5;

  // command table, word and byte address forms
  localparam logic [FA_W-1:0] CA_U1_W = 18'h00555;
  localparam logic [FA_W-1:0] CA_U2_W = 18'h002AA;
  localparam logic [FA_W-1:0] CA_U1_B = 18'h00AAA;
  localparam logic [FA_W-1:0] CA_U2_B = 18'h00555;
  localparam logic [FD_W-1:0] CD_U1 = 16'h00AA;
  localparam logic [FD_W-1:0] CD_U2 = 16'h0055;
  localparam logic [FD_W-1:0] CD_AUTOSEL = 16'h0090;
  localparam logic [FD_W-1:0] CD_PROG = 16'h00A0;
  localparam logic [FD_W-1:0] CD_ERASE = 16'h0080;
  localparam logic [FD_W-1:0] CD_CHIP = 16'h0010;
  localparam logic [FD_W-1:0] CD_RESET = 16'h00F0;
  localparam logic [FA_W-1:0] CA_ANY = 18'h00000;

  // write counts per sequence
  localparam logic [2:0] NW_RESET = 3'h1;
  localparam logic [2:0] NW_AUTOSEL = 3'h3;
  localparam logic [2:0] NW_PROG = 3'h4;
  localparam logic [2:0] NW_ERASE = 3'h6;

  // bus cycle timing in ns
  localparam int T_SETUP_NS = 10;
  localparam int T_WPULSE_NS = 35;
  localparam int T_RACC_NS = 70;
  localparam int T_HOLD_NS = 20;
  localparam int T_BUSY_NS = 90;
  localparam int T_RST_NS = 500;

  // least times rounded up to clock cycles
  localparam logic [CNT_W-1:0] C_SETUP = CNT_W'((T_SETUP_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] C_WPULSE = CNT_W'((T_WPULSE_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] C_RACC = CNT_W'((T_RACC_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] C_HOLD = CNT_W'((T_HOLD_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] C_BUSY = CNT_W'((T_BUSY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] C_RST = CNT_W'((T_RST_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [CNT_W-1:0] CNT_ONE = 8'h01;
  localparam logic [CNT_W-1:0] CNT_ZERO = 8'h00;

  // flash strobe and data pins
  typedef struct packed {
    logic ce_n;
    logic we_n;
    logic oe_n;
    logic [FA_W-1:0] addr;
    logic [FD_W-1:0] dq;
    logic dq_oe;
  } fcm_pins_t;

  // one command write: address and data
  typedef struct packed {
    logic [FA_W-1:0] addr;
    logic [FD_W-1:0] data;
  } fcm_cmd_t;

  // number of command writes for an operation
  function automatic logic [2:0] fcm_nwrites(input logic [2:0] op);
    logic [2:0] n;
    n = NW_RESET;
    if (op == OP_AUTOSEL) n = NW_AUTOSEL;
    if (op == OP_PROG) n = NW_PROG;
    if (op == OP_ERASE) n = NW_ERASE;
    return n;
  endfunction

  // command table lookup for one step of a sequence
  function automatic fcm_cmd_t fcm_cmd(input logic [2:0] op, input logic [2:0] step,
                                       input logic byte_mode, input fcm_cmd_t user);
    fcm_cmd_t c;
    logic [FA_W-1:0] a1;
    logic [FA_W-1:0] a2;
    a1 = byte_mode ? CA_U1_B : CA_U1_W;
    a2 = byte_mode ? CA_U2_B : CA_U2_W;
    c = '{addr: a1, data: CD_U1};
    if (op == OP_RESET)
      c = '{addr: CA_ANY, data: CD_RESET};
    else if (step == 3'h1 || step == 3'h4)
      c = '{addr: a2, data: CD_U2};
    else if (step == 3'h2)
      c.data = (op == OP_AUTOSEL) ? CD_AUTOSEL : (op == OP_PROG) ? CD_PROG : CD_ERASE;
    else if (step == 3'h3 && op == OP_PROG)
      c = user;
    else if (step == 3'h5)
      c.data = CD_CHIP;
    return c;
  endfunction

endpackage

// >>> verif/fcm_flash_model.sv
/*
  behavioural nor flash: command decoder, protection, busy, autoselect.
  assumes strobes synchronous to i_clk; sectors with top address bits 0 protected.
*/
module fcm_flash_model
#(
  parameter logic [15:0] MFR_CODE = 16'h00C3, // arbitrary value
  parameter logic [15:0] DEV_CODE = 16'h0B6E, // arbitrary value
  parameter int BUSY_CYC = 40
)
(
  input wire logic i_clk,
  input wire logic i_por,
  input wire fcm_pkg::fcm_pins_t i_pins,
  input wire logic i_byte_n,
  input wire logic i_reset_n,
  input wire logic i_hv,
  output logic [fcm_pkg::FD_W-1:0] o_dq,
  output logic o_done_n
);
  import fcm_pkg::*;
  logic [FD_W-1:0] mem [logic [FA_W-1:0]]; // stored words, erased when absent
  logic [2:0] st; // command step
  logic asel, stuck, we_q, arm; // modes and strobe history
  logic [FA_W-1:0] la; // latched address
  logic [FD_W-1:0] val, lastv, pd; // read value, last driven, program data
  int bcnt; // busy countdown
  wire [FD_W-1:0] d = i_pins.dq;
  wire [FA_W-1:0] u1 = i_byte_n ? CA_U1_W : CA_U1_B;
  wire [FA_W-1:0] u2 = i_byte_n ? CA_U2_W : CA_U2_B;
  wire wr = i_pins.we_n && !we_q && arm && !i_pins.ce_n && i_pins.oe_n;
  wire busy = stuck || bcnt != 0;
  function automatic logic [FD_W-1:0] rdm(input logic [FA_W-1:0] a);
    return mem.exists(a) ? mem[a] : 16'hFFFF;
  endfunction
  function automatic logic prot(input logic [FA_W-1:0] a);
    return a[FA_W-1:FA_W-3] == 3'h0;
  endfunction
  always @* begin
    logic [7:0] w;
    w = i_byte_n ? i_pins.addr[7:0] : {1'b0, i_pins.addr[7:1]};
    val = busy ? {8'h00, ~pd[7], 1'b0, stuck, 5'h00} : rdm(i_pins.addr);
    if (asel) val = (w == 8'h00) ? MFR_CODE : (w == 8'h01) ? DEV_CODE :
                    {15'h0, prot(i_pins.addr)};
  end
  // released bus shows inverse of last value
  assign o_dq = (!i_pins.ce_n && !i_pins.oe_n) ? val : ~lastv;
  assign o_done_n = !busy;
  always @(posedge i_clk)
  begin
    we_q <= i_pins.we_n;
    if (!i_pins.ce_n && !i_pins.oe_n) lastv <= val;
    if (bcnt != 0) bcnt <= bcnt - 1;
    if (!i_pins.ce_n && !i_pins.we_n && we_q) la <= i_pins.addr;
    if (!i_pins.ce_n && !i_pins.we_n && we_q) arm <= 1'b1;
    if (wr) arm <= 1'b0;
    if (i_por || !i_reset_n)
    begin
      st <= 3'h0; asel <= 1'b0; stuck <= 1'b0; bcnt <= 0; arm <= 1'b0;
    end
    else if (wr && d == CD_RESET && (stuck || bcnt == 0))
    begin
      st <= 3'h0; asel <= 1'b0; stuck <= 1'b0;
    end
    else if (wr && !busy && !asel)
    begin
      st <= 3'h0;
      case (st)
        3'h0: if (la == u1 && d == CD_U1) st <= 3'h1;
        3'h1: if (la == u2 && d == CD_U2) st <= 3'h2;
        3'h4: if (la == u1 && d == CD_U1) st <= 3'h5;
        3'h5: if (la == u2 && d == CD_U2) st <= 3'h6;
        3'h2:
        begin
          if (la == u1 && d == CD_AUTOSEL) asel <= 1'b1;
          if (la == u1 && d == CD_PROG) st <= 3'h3;
          if (la == u1 && d == CD_ERASE) st <= 3'h4;
        end
        3'h3:
        begin
          pd <= d;
          if (!prot(la) || i_hv)
          begin
            mem[la] = rdm(la) & d;
            if ((rdm(la) & d) != d) stuck <= 1'b1;
            else bcnt <= BUSY_CYC;
          end
        end
        3'h6: if (la == u1 && d == CD_CHIP)
        begin
          bcnt <= BUSY_CYC;
          foreach (mem[k]) if (!prot(k) || i_hv) mem[k] = 16'hFFFF;
        end
        default: st <= 3'h0;
      endcase
    end
  end
endmodule

// >>> verif/fcm_host_properties.sv
/*
  checker of the flash strobes and data pins of fcm_host.
  assumes it is bound onto fcm_host, with one clock and a synchronous reset.
*/
module fcm_host_properties
(
  input wire logic I_MCLK,
  input wire logic I_RESET,
  input wire logic O_FL_CE_N,
  input wire logic O_FL_WE_N,
  input wire logic O_FL_OE_N,
  input wire logic [fcm_pkg::FD_W-1:0] O_FL_DQ,
  input wire logic O_FL_DQ_OE
);
  import fcm_pkg::*;
  // one clock domain, quiet during reset
  default clocking cb @(posedge I_MCLK); endclocking
  default disable iff (I_RESET);
  // write strobe low nine cycles
  sequence s_wpulse;
    (!O_FL_WE_N) [*8] ##1 O_FL_WE_N;
  endsequence
  // output strobe low eighteen cycles, write strobe high for the first eight
  sequence s_rpulse;
    (!O_FL_OE_N && O_FL_WE_N) [*8] ##10 (!O_FL_OE_N) ##1 O_FL_OE_N;
  endsequence
  a_no_both_low: assert property (!(!O_FL_WE_N && !O_FL_OE_N))
    else $error("write and output strobes low together");
  a_we_in_ce: assert property (!O_FL_WE_N |-> !O_FL_CE_N)
    else $error("write strobe low without chip select");
  a_dq_no_oe: assert property (O_FL_DQ_OE |-> O_FL_OE_N)
    else $error("data driven while output strobe low");
  a_we_setup: assert property ($fell(O_FL_WE_N) |-> $past(O_FL_CE_N, 3) == 1'b0 && O_FL_DQ_OE)
    else $error("chip select setup before write strobe too short");
  a_we_width: assert property ($fell(O_FL_WE_N) |-> ##1 s_wpulse)
    else $error("write strobe pulse width wrong");
  a_wr_hold: assert property ($rose(O_FL_WE_N) |-> (O_FL_DQ_OE && !O_FL_CE_N && $stable(O_FL_DQ)) [*5])
    else $error("write data not held after strobe");
  a_rd_width: assert property ($fell(O_FL_OE_N) |-> s_rpulse)
    else $error("read strobe width wrong");
endmodule

// >>> verif/testbench.sv
/*
  testbench of fcm_host: ahb-lite master tasks and scenario tasks.
  assumes the flash model on the pins and the checker bound below.
*/
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import fcm_pkg::*;
  localparam logic [15:0] MFR = 16'h00C3; // arbitrary value
  localparam logic [15:0] DEV = 16'h0B6E; // arbitrary value
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, hreadyout, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, st, v;
  logic [1:0] htrans = 2'h0;
  logic [FA_W-1:0] fl_addr;
  logic [FD_W-1:0] dq_in, dq_out;
  logic ce_n, we_n, oe_n, dq_oe, byte_n, frst_n, hv, done_n, hvm = 1'b0, bym = 1'b0;
  fcm_pins_t pins;
  int error_cnt = 0, samples_checked = 0, cyc = 0;
  assign pins = '{ce_n, we_n, oe_n, fl_addr, dq_out, dq_oe};
  // 250 MHz clock
  always #2 clk = ~clk;
  fcm_host fcm_host_inst (.I_MCLK(clk), .I_RESET(rst), .I_HSEL(hsel), .I_HADDR(haddr),
    .I_HTRANS(htrans), .I_HWRITE(hwrite), .I_HSIZE(3'h2), .I_HWDATA(hwdata),
    .I_HREADY(hreadyout), .O_HRDATA(hrdata), .O_HREADYOUT(hreadyout), .O_HRESP(hresp),
    .O_FL_ADDR(fl_addr), .O_FL_CE_N(ce_n), .O_FL_WE_N(we_n), .O_FL_OE_N(oe_n),
    .I_FL_DQ(dq_in), .O_FL_DQ(dq_out), .O_FL_DQ_OE(dq_oe), .O_FL_BYTE_N(byte_n),
    .O_FL_RESET_N(frst_n), .O_FL_HV_REQ(hv), .I_FL_OP_DONE_N(done_n));
  fcm_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .BUSY_CYC(40)) fcm_flash_model_inst (
    .i_clk(clk), .i_por(rst), .i_pins(pins), .i_byte_n(byte_n), .i_reset_n(frst_n),
    .i_hv(hv), .o_dq(dq_in), .o_done_n(done_n));
  task automatic print_verdict();
    if (error_cnt == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // timeout ceiling
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 60000)
    begin
      error_cnt++;
      print_verdict();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      error_cnt++;
    end
  endtask
  // one ahb-lite single transfer
  task automatic ahb(input logic w, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    hsel <= 1'b1; haddr <= {24'h0, a}; htrans <= 2'h2; hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0; htrans <= 2'h0; hwdata <= wd;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // start an operation, poll until idle, clear done and err
  task automatic run(input logic [2:0] op, input logic [31:0] a, input logic [31:0] d);
    int n;
    ahb(1'b1, REG_ADDR, a, v); ahb(1'b1, REG_DATA, d, v);
    ahb(1'b1, REG_CTRL, {25'h0, op, 1'b0, hvm, bym, 1'b1}, v);
    n = 0;
    do begin ahb(1'b0, REG_STAT, 32'h0, st); n++; end while (st[ST_BUSY] !== 1'b0 && n < 3000);
    chk({31'h0, st[ST_BUSY]}, 32'h0);
    ahb(1'b1, REG_STAT, 32'h6, v);
  endtask
  task automatic rdarr(input logic [31:0] a, input logic [31:0] exp);
    run(OP_READ, a, 32'h0);
    ahb(1'b0, REG_RDAT, 32'h0, v);
    chk(v, exp);
  endtask
  task automatic t_reset();
    chk({ce_n, we_n, oe_n, dq_oe, frst_n, hv, byte_n, hreadyout, hresp}, 9'h1D6);
    ahb(1'b0, REG_STAT, 32'h0, v); chk(v & 32'h1F, 32'h10);
    ahb(1'b1, 8'h20, 32'h5A5A, v); ahb(1'b0, 8'h20, 32'h0, v); chk(v, 32'h0);
  endtask
  task automatic t_prog();
    run(OP_PROG, 32'h08000, 32'h1234); chk(st[ST_DONE], 1'b1);
    rdarr(32'h08000, 32'h1234);
  endtask
  task automatic t_prot();
    run(OP_PROG, 32'h00010, 32'h00A5); rdarr(32'h00010, 32'hFFFF);
    hvm = 1'b1; run(OP_PROG, 32'h00010, 32'h00A5); rdarr(32'h00010, 32'h00A5);
    hvm = 1'b0; run(OP_PROG, 32'h00020, 32'h0000); rdarr(32'h00020, 32'hFFFF);
  endtask
  task automatic t_tlimit();
    run(OP_PROG, 32'h08000, 32'hFFFF); chk(st[ST_ERR], 1'b1);
    rdarr(32'h08000, 32'h1234);
  endtask
  task automatic t_asel();
    for (int i = 0; i < 2; i++)
    begin
      run(OP_AUTOSEL, 32'h0, 32'h0); chk(st[ST_AUTOSEL], 1'b1);
      rdarr(32'h0, {16'h0, MFR}); rdarr(32'h1, {16'h0, DEV});
      rdarr(32'h2, 32'h1); rdarr(32'h08002, 32'h0);
      run(i == 0 ? OP_RESET : OP_HWRESET, 32'h0, 32'h0); chk(st[ST_AUTOSEL], 1'b0);
      rdarr(32'h08000, 32'h1234);
    end
  endtask
  task automatic t_byte_erase();
    bym = 1'b1; run(OP_PROG, 32'h10001, 32'h005A); rdarr(32'h10001, 32'h005A);
    bym = 1'b0; run(OP_ERASE, 32'h0, 32'h0); rdarr(32'h08000, 32'hFFFF);
    rdarr(32'h00010, 32'h00A5);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_reset();
    t_prog();
    t_prot();
    t_tlimit();
    t_asel();
    t_byte_erase();
    print_verdict();
  end
endmodule
bind fcm_host fcm_host_properties fcm_host_properties_inst (.I_MCLK(I_MCLK), .I_RESET(I_RESET),
  .O_FL_CE_N(O_FL_CE_N), .O_FL_WE_N(O_FL_WE_N), .O_FL_OE_N(O_FL_OE_N), .O_FL_DQ(O_FL_DQ),
  .O_FL_DQ_OE(O_FL_DQ_OE));
